// ### rtl/pmt_master.sv
// Bus-master termination engine for the disk and network functions.
// How it works
// R01: Master always ends with FRAME and IRDY released.
// R02: STOP with TRDY counts the last word.
// R03: FRAME drops after STOP, IRDY one clock later.
// R04: More data: ask again two clocks later; the code requests again only after a three-clock wait.
// R05: STOP without TRDY: retry same address later.
// R06: Target abort is DEVSEL then STOP.
// R07: Target abort resets and stops network function.
// R08: Disk target abort sets DMA abort flag.
// R09: Target abort sets received-target-abort flag.
// R10: FRAME drops between address phases.
// R11: Arbiter may remove grant while FRAME high.
// R12: Grant lost between phases: finish, release.
// R13: Grant lost in burst: finish word, release.
// R14: Latency timer always reads zero.
// R15: Preempted master keeps its request asserted.
// R16: No DEVSEL in four clocks: master abort.
// R17: Master abort resets and stops network function.
// R18: Disk master abort sets DMA abort flag.
// R19: Master abort sets received-master-abort flag.
// R20: Aborted function idles until software re-initialises.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module pmt_master
  import pmt_pkg::*;
(
  // Clock and reset.
  input  wire logic        I_MCLK,
  input  wire logic        I_SRST,
  // Transfer requests from the DMA engines.
  input  wire logic        I_START,
  input  wire logic        I_FN,
  input  wire logic [31:0] I_ADDR,
  input  wire logic [7:0]  I_WORDS,
  input  wire logic        I_WRITE,
  input  wire logic        I_BURST,
  input  wire logic [31:0] I_WDATA,
  output logic             O_BUSY,
  output logic             O_WORD_ACK,
  output logic [31:0]      O_RDATA,
  output logic             O_DONE,
  // Fatal-error side effects.
  output logic             O_NET_RESET,
  output logic             O_NET_HALT,
  // Bus pins, active low, with enables low while driving.
  input  wire logic [1:0]  I_GNT_N,
  input  wire logic        I_DEVSEL_N,
  input  wire logic        I_TRDY_N,
  input  wire logic        I_STOP_N,
  input  wire logic [31:0] I_AD,
  output logic [1:0]       O_REQ_N,
  output logic             O_FRAME_N,
  output logic             O_FRAME_OE_N,
  output logic             O_IRDY_N,
  output logic             O_IRDY_OE_N,
  output logic [31:0]      O_AD,
  output logic             O_AD_OE_N,
  output logic [3:0]       O_CBE_N,
  output logic             O_CBE_OE_N,
  // Register port.
  input  wire logic [7:0]  I_REG_ADDR,
  input  wire logic [31:0] I_REG_WDATA,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  output logic [31:0]      O_REG_RDATA
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  pmt_state_e  state_r;        // Engine state.
  pmt_state_e  state_nxt;      // Its next value.
  pmt_end_e    end_r;          // Why the tenure ended.
  pmt_end_e    end_nxt;        // Reason found in this data cycle.
  logic [31:0] addr_r;         // Address of the next untransferred word.
  logic [7:0]  words_r;        // Words still to move.
  logic        fn_r;           // Function that owns the transfer.
  logic        write_r;        // Direction of the transfer.
  logic        burst_r;        // Burst or single-word phases.
  logic        seen_r;         // Target claimed this address phase.
  logic [1:0]  halted_r;       // Per function, blocked after an abort.
  logic [1:0]  rta_r;          // Received-target-abort per function.
  logic [1:0]  rma_r;          // Received-master-abort per function.
  logic        dma_abt_r;      // Disk DMA abort flag.
  logic [31:0] ad_r;           // Address or write data driven out.
  logic [3:0]  cbe_r;          // Command or byte enables driven out.
  logic [31:0] rdata_r;        // Last word read.
  logic        ack_r;          // One-cycle word strobe.
  logic        done_r;         // One-cycle completion strobe.
  logic        netrst_r;       // One-cycle network reset strobe.
  logic [31:0] reg_rdata_r;    // Register read data.
  logic [36:0] sync_q;         // Synchronised pins.
  logic [1:0]  gnt_n_s;        // Grants, active low.
  logic        devsel;         // Target claim.
  logic        trdy;           // Target ready.
  logic        stop;           // Target stop.
  logic [31:0] ad_s;           // Read data on the bus.
  logic        gnt_ok;         // Grant of the owning function.
  logic        word;           // A data phase completes now.
  logic        last;           // It is the final word.
  logic        tabt;           // Target abort seen.
  logic        mabt;           // Master abort due.
  logic        leave;          // The data phase ends now.
  logic        abort;          // Either abort fires now.
  logic        tmr_load;       // Start the shared timer.
  logic [2:0]  tmr_val;        // Count for the timer.
  logic        tmr_done;       // Timer ran out.
  logic        wr_clr;         // Write strobe of the control register.
  logic [1:0]  stat_clr;       // Write-one-to-clear per status register.

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and helpers.
  // Every pin crosses two flops; the engine therefore reacts two clocks late,
  // which the devsel window compensates for.
  pmt_sync #(.W(37)) u_sync (
    .i_clk  (I_MCLK),
    .i_srst (I_SRST),
    .i_d    ({I_GNT_N, I_DEVSEL_N, I_TRDY_N, I_STOP_N, I_AD}),
    .o_q    (sync_q)
  );
  assign gnt_n_s = sync_q[36:35];
  assign devsel  = !sync_q[34];
  assign trdy    = !sync_q[33];
  assign stop    = !sync_q[32];
  assign ad_s    = sync_q[31:0];
  assign gnt_ok  = !gnt_n_s[fn_r];

  // One timer serves the devsel window and the re-request gap; they never overlap.
  pmt_timer u_tmr (
    .i_clk  (I_MCLK),
    .i_srst (I_SRST),
    .i_load (tmr_load),
    .i_val  (tmr_val),
    .o_done (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Termination decisions in the data phase.
  always_comb begin
    word  = (state_r == ST_DATA) && trdy;
    last  = (words_r == 8'h01);
    tabt  = (state_r == ST_DATA) && stop && !devsel && seen_r;  // [R06]
    mabt  = (state_r == ST_DATA) && !seen_r && !devsel && tmr_done;  // [R16]
    abort = tabt || mabt;
    leave = 1'b0;
    end_nxt = end_r;
    if (mabt) begin
      leave   = 1'b1;
      end_nxt = END_MABT;
    end else if (tabt) begin
      leave   = 1'b1;
      end_nxt = END_TABT;
    end else if ((state_r == ST_DATA) && stop) begin
      // A word moved beside STOP still counts.
      leave   = 1'b1;
      end_nxt = (trdy && last) ? END_DONE : END_DISC;  // [R02] [R05]
    end else if (word && last) begin
      leave   = 1'b1;
      end_nxt = END_DONE;
    end else if (word && !burst_r) begin
      leave   = 1'b1;
      end_nxt = END_NEXT;  // [R10]
    end else if (word && !gnt_ok) begin
      leave   = 1'b1;
      end_nxt = END_PRE;  // [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    state_nxt = state_r;
    tmr_load  = 1'b0;
    tmr_val   = DEVSEL_LOAD;
    unique case (state_r)
      ST_IDLE: begin
        // A halted function is refused until software releases it.
        if (I_START && !halted_r[I_FN]) begin  // [R20]
          state_nxt = ST_REQ;
        end
      end
      ST_REQ: begin
        if (gnt_ok) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        tmr_load  = 1'b1;
        state_nxt = ST_DATA;
      end
      ST_DATA: begin
        if (leave) begin
          state_nxt = ST_FEND;  // [R03]
        end
      end
      ST_FEND: begin
        state_nxt = ST_GAP;  // [R01] [R03]
      end
      ST_GAP: begin
        unique case (end_r)
          END_PRE:  state_nxt = ST_REQ;  // [R15]
          END_NEXT: state_nxt = gnt_ok ? ST_ADDR : ST_REQ;  // [R12]
          END_DISC: begin
            if (words_r != 8'h00) begin
              tmr_load  = 1'b1;
              tmr_val   = REREQ_GAP_CLK;
              state_nxt = ST_WAIT;  // [R04] [R05]
            end else begin
              state_nxt = ST_IDLE;
            end
          end
          default:  state_nxt = ST_IDLE;  // Done or aborted, no retry. [R20]
        endcase
      end
      ST_WAIT: begin
        if (tmr_done) begin
          state_nxt = ST_REQ;  // [R04]
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      state_r <= ST_IDLE;
      end_r   <= END_DONE;
    end else begin
      state_r <= state_nxt;
      end_r   <= end_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer bookkeeping.
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      addr_r  <= 32'h0000_0000;
      words_r <= 8'h00;
      fn_r    <= FN_DISK;
      write_r <= 1'b0;
      burst_r <= 1'b0;
    end else if ((state_r == ST_IDLE) && (state_nxt == ST_REQ)) begin
      addr_r  <= I_ADDR;
      words_r <= I_WORDS;
      fn_r    <= I_FN;
      write_r <= I_WRITE;
      burst_r <= I_BURST;
    end else if (word) begin
      // Resume point is always the next untransferred word.
      addr_r  <= addr_r + ADDR_STEP;  // [R02] [R04]
      words_r <= words_r - 8'h01;
    end
  end

  // Target claim tracking, restarted with each address phase.
  always_ff @(posedge I_MCLK) begin
    if (I_SRST || (state_r == ST_ADDR)) begin
      seen_r <= 1'b0;
    end else if ((state_r == ST_DATA) && devsel) begin
      seen_r <= 1'b1;
    end
  end

  // Address, command and data driven onto the bus.
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      ad_r  <= 32'h0000_0000;
      cbe_r <= CBE_ALL;
    end else if (state_nxt == ST_ADDR) begin
      ad_r  <= addr_r;
      cbe_r <= write_r ? CMD_MEM_WR : (burst_r ? CMD_MEM_RD_LINE : CMD_MEM_RD);
    end else if ((state_r == ST_ADDR) || word) begin
      ad_r  <= write_r ? I_WDATA : ad_r;
      cbe_r <= CBE_ALL;
    end
  end

  // Read capture and user strobes.
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      rdata_r <= 32'h0000_0000;
      ack_r   <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      if (word && !write_r) begin
        rdata_r <= ad_s;
      end
      ack_r  <= word;
      done_r <= (state_r == ST_GAP) && (state_nxt == ST_IDLE) && (end_r < END_TABT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Abort side effects; a set in the same cycle as a clear wins.
  assign wr_clr   = I_REG_WR && (I_REG_ADDR == CTRL_OFS);
  assign stat_clr = {I_REG_WR && (I_REG_ADDR == STAT_B_OFS),
                     I_REG_WR && (I_REG_ADDR == STAT_A_OFS)};

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      rta_r     <= FLAG_RST;
      rma_r     <= FLAG_RST;
      halted_r  <= FLAG_RST;
      dma_abt_r <= 1'b0;
      netrst_r  <= 1'b0;
    end else begin
      for (int f = 0; f < 2; f++) begin
        if (abort && (fn_r == f[0])) begin
          rta_r[f]    <= rta_r[f] | tabt;  // [R09]
          rma_r[f]    <= rma_r[f] | mabt;  // [R19]
          halted_r[f] <= 1'b1;  // [R20]
        end else begin
          if (stat_clr[f]) begin
            rta_r[f] <= rta_r[f] & ~I_REG_WDATA[RTA_BIT];
            rma_r[f] <= rma_r[f] & ~I_REG_WDATA[RMA_BIT];
          end
          if (wr_clr && I_REG_WDATA[CTRL_REINIT_A + f]) begin
            halted_r[f] <= 1'b0;
          end
        end
      end
      // Disk aborts raise no interrupt; besides their status and halt flags they set this flag.
      if (abort && (fn_r == FN_DISK)) begin
        dma_abt_r <= 1'b1;  // [R08] [R18]
      end else if (I_REG_WR && (I_REG_ADDR == DMA_STAT_OFS) && I_REG_WDATA[DMA_ABT_BIT]) begin
        dma_abt_r <= 1'b0;
      end
      netrst_r <= abort && (fn_r == FN_NET);  // [R07] [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port; unmapped offsets read zero.
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      reg_rdata_r <= 32'h0000_0000;
    end else if (I_REG_RD) begin
      unique case (I_REG_ADDR)
        STAT_A_OFS:   reg_rdata_r <= {18'h0, rma_r[0], rta_r[0], 12'h0};
        STAT_B_OFS:   reg_rdata_r <= {18'h0, rma_r[1], rta_r[1], 12'h0};
        LAT_OFS:      reg_rdata_r <= {24'h0, LAT_VAL};  // [R14]
        INFO_OFS:     reg_rdata_r <= {27'h0, halted_r, state_r};
        DMA_STAT_OFS: reg_rdata_r <= {29'h0, dma_abt_r, 2'h0};
        default:      reg_rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and user outputs.
  always_comb begin
    O_REQ_N = 2'h3;
    // Request is raised again from the end of a preempted tenure.
    if ((state_r == ST_REQ) ||
        (((state_r == ST_FEND) || (state_r == ST_GAP)) && (end_r == END_PRE))) begin
      O_REQ_N[fn_r] = 1'b0;  // [R15]
    end
  end
  assign O_FRAME_N    = !((state_r == ST_ADDR) || (state_r == ST_DATA));
  assign O_IRDY_N     = !((state_r == ST_DATA) || (state_r == ST_FEND));
  // Both lines are driven high for one idle clock before release. [R01]
  assign O_FRAME_OE_N = !((state_r == ST_ADDR) || (state_r == ST_DATA) ||
                          (state_r == ST_FEND) || (state_r == ST_GAP));
  assign O_IRDY_OE_N  = O_FRAME_OE_N;
  assign O_AD         = ad_r;
  assign O_AD_OE_N    = !((state_r == ST_ADDR) || ((state_r == ST_DATA) && write_r));
  assign O_CBE_N      = cbe_r;
  assign O_CBE_OE_N   = !((state_r == ST_ADDR) || (state_r == ST_DATA));
  assign O_BUSY       = (state_r != ST_IDLE);
  assign O_WORD_ACK   = ack_r;
  assign O_RDATA      = rdata_r;
  assign O_DONE       = done_r;
  assign O_NET_RESET  = netrst_r;
  assign O_NET_HALT   = halted_r[FN_NET];
  assign O_REG_RDATA  = reg_rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);

  chk_end_idle: assert property ((state_r == ST_FEND) |=> // [R01]
      (O_FRAME_N && O_IRDY_N && !O_FRAME_OE_N) ##1 (O_FRAME_OE_N || (state_r == ST_ADDR)))
    else $error("bus not left idle after termination");
  chk_stop_seq: assert property ((state_r == ST_DATA) && stop |=> // [R03]
      (O_FRAME_N && !O_IRDY_N) ##1 O_IRDY_N)
    else $error("frame and irdy not released in order after stop");
  chk_stop_word: assert property ((state_r == ST_DATA) && stop && trdy && !tabt |=> // [R02]
      words_r == $past(words_r) - 8'h01)
    else $error("word beside stop not counted");
  chk_rereq_gap: assert property ($rose(state_r == ST_WAIT) |-> // [R04]
      (state_r == ST_WAIT)[*3] ##1 (state_r == ST_REQ))
    else $error("re-request gap wrong");
  chk_retry_addr: assert property ((state_r == ST_DATA) && stop && !trdy && !tabt |=> // [R05]
      $stable(addr_r))
    else $error("retry address moved");
  chk_mabt_flag: assert property (mabt |-> ##1 (rma_r[fn_r] && halted_r[fn_r])) // [R19]
    else $error("master abort flag not set");
  chk_tabt_flag: assert property (tabt |-> ##1 (rta_r[fn_r] && (state_r == ST_FEND))) // [R09]
    else $error("target abort flag not set");
  chk_disk_abt: assert property (abort && (fn_r == FN_DISK) |=> dma_abt_r && !O_NET_RESET) // [R08]
    else $error("disk abort flag missing");
  chk_net_rst: assert property (abort && (fn_r == FN_NET) |=> O_NET_RESET ##1 !O_NET_RESET) // [R17]
    else $error("network reset pulse wrong");
  chk_mabt_time: assert property ($rose(state_r == ST_DATA) ##0 (!devsel && !stop)[*7] |=> // [R16]
      (state_r == ST_FEND))
    else $error("master abort not taken in time");
  chk_no_retry: assert property ((state_r == ST_GAP) && (end_r >= END_TABT) |=> // [R20]
      (state_r == ST_IDLE) && halted_r[fn_r])
    else $error("aborted transfer retried");
  chk_lat_zero: assert property (I_REG_RD && (I_REG_ADDR == LAT_OFS) |=> // [R14]
      O_REG_RDATA == 32'h0000_0000)
    else $error("latency timer not zero");
  chk_pre_req: assert property ((state_r == ST_DATA) && (end_nxt == END_PRE) && leave |=> // [R15]
      !O_REQ_N[fn_r] [*3])
    else $error("request dropped after preemption");

endmodule : pmt_master

// ### rtl/pmt_pkg.sv
// Package with the constants and types of the bus-master termination engine.
package pmt_pkg;

  // Register byte offsets on the plain register port.
  localparam logic [7:0] STAT_A_OFS   = 8'h04;  // Status of the disk function.
  localparam logic [7:0] STAT_B_OFS   = 8'h08;  // Status of the network function.
  localparam logic [7:0] LAT_OFS      = 8'h0C;  // Latency timer, fixed value.
  localparam logic [7:0] CTRL_OFS     = 8'h10;  // Re-initialise control.
  localparam logic [7:0] INFO_OFS     = 8'h14;  // Engine state and halt flags.
  localparam logic [7:0] DMA_STAT_OFS = 8'h54;  // Disk DMA status.

  // Field positions.
  localparam int RTA_BIT       = 12;  // Received-target-abort flag.
  localparam int RMA_BIT       = 13;  // Received-master-abort flag.
  localparam int DMA_ABT_BIT   = 2;   // DMA abort flag.
  localparam int CTRL_REINIT_A = 0;   // Write one to release the disk function.
  localparam int CTRL_REINIT_B = 1;   // Write one to release the network function.

  // Reset and fixed values.
  localparam logic [1:0]  FLAG_RST = 2'h0;
  localparam logic [7:0]  LAT_VAL  = 8'h00;

  // Timing counts in clock cycles.
  localparam logic [2:0] DEVSEL_WAIT_CLK = 3'h4;  // Clocks allowed for target claim.
  localparam logic [2:0] SYNC_LAT_CLK    = 3'h2;  // Delay of the input synchroniser.
  localparam logic [2:0] DEVSEL_LOAD     = DEVSEL_WAIT_CLK + SYNC_LAT_CLK;
  localparam logic [2:0] REREQ_GAP_CLK   = 3'h2;  // Timer load for the re-request wait, which lasts three clocks.

  // Bus commands and byte enables.
  localparam logic [3:0] CMD_MEM_RD      = 4'h6;
  localparam logic [3:0] CMD_MEM_WR      = 4'h7;
  localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
  localparam logic [3:0] CBE_ALL         = 4'h0;
  localparam logic [31:0] ADDR_STEP      = 32'h0000_0004;

  // Function numbers.
  localparam logic FN_DISK = 1'b0;
  localparam logic FN_NET  = 1'b1;

  // Engine states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ  = 3'b001,
    ST_ADDR = 3'b011,
    ST_DATA = 3'b010,
    ST_FEND = 3'b110,
    ST_GAP  = 3'b111,
    ST_WAIT = 3'b101
  } pmt_state_e;

  // Reason that ended the last bus tenure.
  typedef enum logic [2:0] {
    END_DONE = 3'h0,
    END_NEXT = 3'h1,
    END_PRE  = 3'h2,
    END_DISC = 3'h3,
    END_TABT = 3'h4,
    END_MABT = 3'h5
  } pmt_end_e;

endpackage : pmt_pkg

// ### rtl/pmt_sync.sv
// Two-flop synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ps
module pmt_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  // Raw and synchronised levels.
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  genvar g;
  // One pair of flops per bit; idle bus lines are high, so reset to one.
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      logic meta_r;  // Read only by the second flop.
      logic hold_r;  // Safe copy.
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          meta_r <= 1'b1;
          hold_r <= 1'b1;
        end else begin
          meta_r <= i_d[g];
          hold_r <= meta_r;
        end
      end
      assign o_q[g] = hold_r;
    end
  endgenerate
endmodule : pmt_sync

// ### rtl/pmt_timer.sv
// Small down counter that flags when a loaded number of clocks has passed.
`timescale 1ns/1ps
module pmt_timer (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  // Load strobe and count.
  input  wire logic       i_load,
  input  wire logic [2:0] i_val,
  // Level, high once the count has run out.
  output logic            o_done
);
  logic [2:0] cnt_r;  // Remaining clocks.
  logic       run_r;  // Set by a load, cleared only by reset.

  // A load restarts the count; otherwise count down to zero and stay.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_r <= 3'h0;
      run_r <= 1'b0;
    end else if (i_load) begin
      cnt_r <= i_val;
      run_r <= 1'b1;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end

  assign o_done = run_r && (cnt_r == 3'h0);
endmodule : pmt_timer

// ### sim/pmt_far_model.sv
// Behavioural bus target and central arbiter facing the termination engine.
`timescale 1ns/1ps
module pmt_far_model #(
  parameter logic [31:0] RD_WORD = 32'h1234_5678  // Read pattern, arbitrary.
) (
  // Clock, behaviour select (0 ok, 1 silent, 2 retry, 3 abort) and bus levels.
  input  wire logic       i_clk,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_frame_n,
  input  wire logic       i_irdy_n,
  input  wire logic [1:0] i_req_n,
  // Arbiter and target replies.
  output logic [1:0]      o_gnt_n,
  output logic            o_devsel_n,
  output logic            o_trdy_n,
  output logic            o_stop_n,
  output logic [31:0]     o_ad
);
  logic       act_r = 1'b0;  // Target has claimed the current transaction.
  logic [3:0] cnt_r = 4'h0;  // Clocks since the claim, saturating.
  ////////////////////////////////
  // Grant follows request; the target stays claimed until the bus idles.
  always_ff @(posedge i_clk) begin
    o_gnt_n <= i_req_n;
    if (act_r && i_frame_n && i_irdy_n) act_r <= 1'b0;
    else if (!i_frame_n) act_r <= 1'b1;
    cnt_r <= act_r ? cnt_r + {3'h0, cnt_r != 4'hF} : 4'h0;
  end
  // An abort claims for one clock only, then stops; a retry stops without ready.
  assign o_devsel_n = !(act_r && i_mode != 2'h1 && !(i_mode == 2'h3 && cnt_r > 4'h0));
  assign o_stop_n   = !(act_r && i_mode[1] && cnt_r > 4'h0);
  assign o_trdy_n   = !(act_r && i_mode == 2'h0 && cnt_r > 4'h0 && !i_irdy_n);
  // Undriven data lines show the inverse, so stale values never look valid.
  assign o_ad       = o_trdy_n ? ~RD_WORD : RD_WORD;
endmodule : pmt_far_model

// ### sim/pci_master_termination_test.sv
// Self-checking bench for the bus-master termination engine.
`timescale 1ns/1ps
module pci_master_termination_test;
  import pmt_pkg::*;
  localparam logic [31:0] RD_WORD = 32'h1234_5678;  // Arbitrary read pattern.
  // Bench-driven inputs; writes are tied off, only reads are exercised.
  logic        clk = 1'b0, srst = 1'b1, start = 1'b0, fn = 1'b0, burst = 1'b0;
  logic        rwr = 1'b0, rrd = 1'b0;
  logic [31:0] addr = 32'h0, rwd = 32'h0;
  logic [7:0]  words = 8'h1, ra = 8'h0;
  logic [1:0]  mode = 2'h0;
  // Design outputs and resolved bus levels.
  logic        busy, ack, done, net_rst, net_halt, devsel_n, trdy_n, stop_n;
  logic        frame_n, frame_oe_n, irdy_n, irdy_oe_n, ad_oe_n, cbe_oe_n;
  logic [1:0]  gnt_n, req_n;
  logic [3:0]  cbe_n;
  logic [31:0] rdata, ad_out, far_ad, rrd_data;
  wire         frame_w = frame_oe_n | frame_n;  // Pulled up when released.
  wire         irdy_w  = irdy_oe_n | irdy_n;
  wire  [31:0] ad_w    = ad_oe_n ? far_ad : ad_out;
  // Bench bookkeeping.
  int          err_total = 0, check_count = 0, acks = 0, dones = 0, nrst = 0, run = 0, gap = 0;
  logic [31:0] lst_a = 32'h0, prv_a = 32'h0, bit_e;
  logic        fr_q = 1'b1, f;
  logic [1:0]  m;
  pmt_master DUT (
    .I_MCLK(clk), .I_SRST(srst), .I_START(start), .I_FN(fn), .I_ADDR(addr),
    .I_WORDS(words), .I_WRITE(1'b0), .I_BURST(burst), .I_WDATA(32'h0), .O_BUSY(busy),
    .O_WORD_ACK(ack), .O_RDATA(rdata), .O_DONE(done), .O_NET_RESET(net_rst),
    .O_NET_HALT(net_halt), .I_GNT_N(gnt_n), .I_DEVSEL_N(devsel_n), .I_TRDY_N(trdy_n),
    .I_STOP_N(stop_n), .I_AD(ad_w), .O_REQ_N(req_n), .O_FRAME_N(frame_n),
    .O_FRAME_OE_N(frame_oe_n), .O_IRDY_N(irdy_n), .O_IRDY_OE_N(irdy_oe_n), .O_AD(ad_out),
    .O_AD_OE_N(ad_oe_n), .O_CBE_N(cbe_n), .O_CBE_OE_N(cbe_oe_n), .I_REG_ADDR(ra),
    .I_REG_WDATA(rwd), .I_REG_WR(rwr), .I_REG_RD(rrd), .O_REG_RDATA(rrd_data));
  pmt_far_model #(.RD_WORD(RD_WORD)) far (
    .i_clk(clk), .i_mode(mode), .i_frame_n(frame_w), .i_irdy_n(irdy_w), .i_req_n(req_n),
    .o_gnt_n(gnt_n), .o_devsel_n(devsel_n), .o_trdy_n(trdy_n), .o_stop_n(stop_n),
    .o_ad(far_ad));
  initial forever #2 clk = ~clk;
  ////////////////////////////////
  // Counts pulses, logs address phases and the idle gap before a re-request.
  always @(posedge clk) begin
    acks += ack;
    dones += done;
    nrst += net_rst;
    if (!frame_w && fr_q) begin
      prv_a = lst_a;
      lst_a = ad_out;
    end
    fr_q = frame_w;
    if (busy && frame_oe_n && req_n[fn]) run++;
    else begin
      if (run > 0) gap = run;
      run = 0;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask : reg_wr
  // Read data stand from the cycle after the strobe until the next read strobe.
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    @(negedge clk);
    chk(nm, exp, rrd_data);
  endtask : reg_chk
  // One transfer; a retrying far side turns well-behaved once the gap is seen.
  task automatic xfer(input logic fi, input logic [31:0] a, input logic [7:0] n,
                      input logic b, input logic [1:0] md);
    acks = 0;
    dones = 0;
    nrst = 0;
    gap = 0;
    mode = md;
    @(posedge clk);
    start <= 1'b1;
    fn <= fi;
    addr <= a;
    words <= n;
    burst <= b;
    @(posedge clk);
    start <= 1'b0;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (busy === 1'b0) break;
      if (gap != 0) mode = 2'h0;
    end
    @(negedge clk);  // The done pulse of the first idle cycle is counted first.
    chk("busy", 32'h0, {31'h0, busy});
  endtask : xfer
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial begin
    #80000;
    err_total++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("idle bus", 32'h3, {30'h0, req_n & {2{frame_w & irdy_w}}});
    reg_chk(LAT_OFS, 32'h0, "latency");
    reg_chk(8'h40, 32'h0, "unmapped");
    xfer(FN_DISK, 32'h0000_0100, 8'h2, 1'b0, 2'h0);
    chk("acks", 32'h2, acks);
    chk("addr 1", 32'h0000_0100, prv_a);
    chk("addr 2", 32'h0000_0104, lst_a);
    chk("rdata", RD_WORD, rdata);
    chk("idle", 32'h1, {31'h0, frame_w & irdy_w});
    $display("test single phases done");
    xfer(FN_NET, 32'h0000_0140, 8'h2, 1'b1, 2'h0);
    chk("preempt acks", 32'h2, acks);
    chk("preempt addr", 32'h0000_0144, lst_a);
    chk("preempt done", 32'h1, dones);
    $display("test preemption done");
    xfer(FN_DISK, 32'h0000_0180, 8'h1, 1'b1, 2'h2);
    chk("gap", 32'h3, gap);
    chk("retry addr", 32'h0000_0180, prv_a & lst_a);
    chk("retry done", 32'h1, dones);
    $display("test retry done");
    // Every abort kind on every function, then refusal and release.
    for (int k = 0; k < 4; k++) begin
      f = k[0];
      m = k[1] ? 2'h3 : 2'h1;
      bit_e = (m == 2'h1) ? 32'h2000 : 32'h1000;
      xfer(f, 32'h0000_0200, 8'h2, 1'b1, m);
      chk("abort done", 32'h0, dones);
      chk("net reset", {31'h0, f}, nrst);
      chk("net halt", {31'h0, f}, {31'h0, net_halt});
      reg_chk(f ? STAT_B_OFS : STAT_A_OFS, bit_e, "status");
      reg_chk(DMA_STAT_OFS, f ? 32'h0 : 32'h4, "dma status");
      xfer(f, 32'h0000_0300, 8'h1, 1'b1, 2'h0);
      chk("halted acks", 32'h0, acks);
      reg_wr(CTRL_OFS, f ? 32'h2 : 32'h1);
      reg_wr(f ? STAT_B_OFS : STAT_A_OFS, bit_e);
      reg_wr(DMA_STAT_OFS, 32'h4);
      xfer(f, 32'h0000_0300, 8'h1, 1'b1, 2'h0);
      chk("released acks", 32'h1, acks);
      reg_chk(f ? STAT_B_OFS : STAT_A_OFS, 32'h0, "status cleared");
    end
    $display("test aborts done");
    end_sim();
  end
endmodule : pci_master_termination_test
